// >>> logic/jcsc_top.sv
/*
 jcsc_top: jack clamp and general-purpose switch control with APB slave.
 assumes: APB3 master on clock; jack sense, slow clock and sleep arrive
 as asynchronous pins; outputs drive analog clamp and switch gates.
*/
// Added by the designer: the APB slave port.
// Operation
// - clamp A force bit 4, reset 1, forces clamp A on.
// - clamp A select 3:0, reset 0; 0 off, 1 on, 2-3 reserved.
// - codes 4-7: sense A low, A high, B low, B high.
// - codes 8-B: OR pairs of sense A and sense B levels.
// - code C both low, code D A low and B high.
// - switch B field 3:2, switch A field 1:0, reset 00.
// - switch code 00 open, 01 closed.
// - code 10 closed while status set, 11 closed while clear.
// - one status, mirrored at bit 4 twice, ignores forced clamps.
// - debounce enable bit 4, reset 0, debounces clamp status.
// - both clamps come up on after any reset.
// - insertion and removal visible through status bits and events.
// - on removal clamp turns on by its condition alone.
// - clamp B codes 0 off, 1 on, 2 sense C low, 3 high.
// - with debounce off, rise and fall events only when sense inputs moved status.
// - two enables, reset 0, let status edges start the sequencer.
// - debounce runs on slow clock, bypassed in sleep.
`timescale 1ns/1ps
`default_nettype none

module jcsc_top
    import jcsc_pkg::*;
#(
    parameter int DB_COUNT = DB_TICKS
) (
    input  wire logic              clock,           // 25 MHz system clock
    input  wire logic              rst_n,           // async reset, active low
    input  wire logic              psel,            // apb select
    input  wire logic              penable,         // apb enable
    input  wire logic              pwrite,          // apb direction
    input  wire logic [ADDR_W-1:0] paddr,           // apb byte address
    input  wire logic [DATA_W-1:0] pwdata,          // apb write data
    output logic      [DATA_W-1:0] prdata,          // apb read data
    output logic                   pready,          // apb ready
    output logic                   pslverr,         // apb error, unmapped
    input  wire logic              jack_sense_a,    // jack detect pin a
    input  wire logic              jack_sense_b,    // jack detect pin b
    input  wire logic              jack_sense_c,    // jack detect pin c
    input  wire logic              slow_clk_32k,    // 32 kHz clock pin
    input  wire logic              sleep_mode,      // sleep level pin
    output logic                   clamp_a_on,      // clamp a shorts pins
    output logic                   clamp_b_on,      // clamp b shorts pins
    output logic                   switch_a_closed, // switch a contacts
    output logic                   switch_b_closed, // switch b contacts
    output logic                   clamp_rise_evt,  // status rose, pulse
    output logic                   clamp_fall_evt,  // status fell, pulse
    output logic                   seq_trigger      // sequencer start pulse
);

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_n_i;

    // two-flop release of the async reset
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n_i = rst_sync_r;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] pins_s;
    logic       js_a;
    logic       js_b;
    logic       js_c;
    logic       clk32_s;
    logic       sleep_s;
    logic       clk32_prev_r;
    logic       tick;

    // sense, slow clock and sleep pins into the clock domain
    jcsc_sync #(.W(5)) u_sync (
        .clock (clock),
        .rst_n (rst_n_i),
        .din   ({sleep_mode, slow_clk_32k, jack_sense_c, jack_sense_b, jack_sense_a}),
        .dout  (pins_s)
    );
    assign js_a    = pins_s[0];
    assign js_b    = pins_s[1];
    assign js_c    = pins_s[2];
    assign clk32_s = pins_s[3];
    assign sleep_s = pins_s[4];

    // slow clock rising edge gives one debounce tick
    always_ff @(posedge clock or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clk32_prev_r <= 1'b0;
        end else begin
            clk32_prev_r <= clk32_s;
        end
    end
    assign tick = clk32_s & ~clk32_prev_r;

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    jcsc_clamp_cfg_t  clamp_cfg_r;
    jcsc_switch_cfg_t sw_cfg_r;
    logic             db_en_r;
    logic [1:0]       seq_en_r;
    logic             status_r;
    logic [13:0]      idx;
    logic [DATA_W-1:0] rd_data;
    logic             rd_hit;
    logic             wr_go;

    assign idx   = paddr[15:2];
    assign wr_go = psel & penable & pwrite & pready & rd_hit;

    // read mux; also decides whether an address is mapped
    always_comb begin
        rd_data = '0;
        rd_hit  = 1'b1;
        case (idx)
            IDX_SEQ_CTRL:  rd_data[1:0] = seq_en_r;
            IDX_CLAMP_CTL: rd_data[9:0] = clamp_cfg_r;
            IDX_GP_SWITCH: rd_data[3:0] = sw_cfg_r;
            IDX_RAW_STS_A: rd_data[STS_BIT] = status_r;
            IDX_RAW_STS_B: rd_data[STS_BIT] = status_r;
            IDX_DB_CTRL:   rd_data[DB_BIT] = db_en_r;
            default:       rd_hit = 1'b0;
        endcase
    end

    // one wait state: ready in second access cycle with data
    always_ff @(posedge clock or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            prdata  <= (psel & penable & ~pready & ~pwrite) ? rd_data : '0;
            pslverr <= psel & penable & ~pready & ~rd_hit;
        end
    end

    // clamp control register; force bits come up set
    always_ff @(posedge clock or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clamp_cfg_r <= CLAMP_RST;
        end else if (wr_go && idx == IDX_CLAMP_CTL) begin
            clamp_cfg_r      <= pwdata[9:0];
            clamp_cfg_r.rsvd <= 1'b0;
        end
    end

    // switch control register
    always_ff @(posedge clock or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sw_cfg_r <= SWITCH_RST;
        end else if (wr_go && idx == IDX_GP_SWITCH) begin
            sw_cfg_r <= pwdata[3:0];
        end
    end

    // debounce and sequencer enables
    always_ff @(posedge clock or negedge rst_n_i) begin
        if (!rst_n_i) begin
            db_en_r  <= DB_RST;
            seq_en_r <= SEQ_RST;
        end else begin
            if (wr_go && idx == IDX_DB_CTRL) begin
                db_en_r <= pwdata[DB_BIT];
            end
            if (wr_go && idx == IDX_SEQ_CTRL) begin
                seq_en_r <= pwdata[1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // condition decode
    // ----------------------------------------------------------------
    logic cond_a;
    logic cond_b;
    logic status_raw;

    // clamp a condition from sense a and b
    always_comb begin
        cond_a = 1'b0;
        case (clamp_cfg_r.a_sel)
            A_ON:          cond_a = 1'b1;
            A_A_LO:        cond_a = ~js_a;
            A_A_HI:        cond_a = js_a;
            A_B_LO:        cond_a = ~js_b;
            A_B_HI:        cond_a = js_b;
            A_ALO_OR_BLO:  cond_a = ~js_a | ~js_b;
            A_ALO_OR_BHI:  cond_a = ~js_a | js_b;
            A_AHI_OR_BLO:  cond_a = js_a | ~js_b;
            A_AHI_OR_BHI:  cond_a = js_a | js_b;
            A_ALO_AND_BLO: cond_a = ~js_a & ~js_b;
            A_ALO_AND_BHI: cond_a = ~js_a & js_b;
            default:       cond_a = 1'b0;             // off, reserved
        endcase
    end

    // clamp b condition from sense c
    always_comb begin
        cond_b = 1'b0;
        case (clamp_cfg_r.b_sel)
            B_ON:    cond_b = 1'b1;
            B_C_LO:  cond_b = ~js_c;
            B_C_HI:  cond_b = js_c;
            default: cond_b = 1'b0;
        endcase
    end

    // shared status follows clamp a when it is not forced, else clamp b when it is not forced
    assign status_raw = ~clamp_cfg_r.a_force ? cond_a :
                        (~clamp_cfg_r.b_force ? cond_b : 1'b0);

    // ----------------------------------------------------------------
    // clamp and switch drive
    // ----------------------------------------------------------------
    // condition re-applies on removal with no software step
    always_ff @(posedge clock or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clamp_a_on <= 1'b1;
            clamp_b_on <= 1'b1;
        end else begin
            clamp_a_on <= clamp_cfg_r.a_force | cond_a;
            clamp_b_on <= clamp_cfg_r.b_force | cond_b;
        end
    end

    function automatic logic sw_dec(input logic [1:0] m, input logic st);
        case (m)
            SW_CLOSED: sw_dec = 1'b1;
            SW_IF_SET: sw_dec = st;
            SW_IF_CLR: sw_dec = ~st;
            default:   sw_dec = 1'b0;   // open
        endcase
    endfunction

    // switch contacts from their fields and the status
    always_ff @(posedge clock or negedge rst_n_i) begin
        if (!rst_n_i) begin
            switch_a_closed <= 1'b0;
            switch_b_closed <= 1'b0;
        end else begin
            switch_a_closed <= sw_dec(sw_cfg_r.a, status_r);
            switch_b_closed <= sw_dec(sw_cfg_r.b, status_r);
        end
    end

    // ----------------------------------------------------------------
    // status debounce and edge events
    // ----------------------------------------------------------------
    logic            status_prev_r;
    jcsc_clamp_cfg_t cfg_prev_r;
    jcsc_clamp_cfg_t cfg_prev2_r;
    logic            cfg_quiet;
    logic            rise;
    logic            fall;

    // debounce is bypassed while asleep
    jcsc_debounce #(.TICKS(DB_COUNT)) u_db (
        .clock  (clock),
        .rst_n  (rst_n_i),
        .raw    (status_raw),
        .tick   (tick),
        .enable (db_en_r & ~sleep_s),
        .dout   (status_r)
    );

    // a config write marks a status change within the next two edges as software made
    always_ff @(posedge clock or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_prev_r <= 1'b0;
            cfg_prev_r    <= CLAMP_RST;
            cfg_prev2_r   <= CLAMP_RST;
        end else begin
            status_prev_r <= status_r;
            cfg_prev_r    <= clamp_cfg_r;
            cfg_prev2_r   <= cfg_prev_r;
        end
    end
    // undebounced status lags the config by one edge, so look two edges back
    assign cfg_quiet = (cfg_prev_r == clamp_cfg_r) && (cfg_prev2_r == cfg_prev_r);
    assign rise      = status_r & ~status_prev_r & cfg_quiet;
    assign fall      = ~status_r & status_prev_r & cfg_quiet;

    // event pulses and sequencer start
    always_ff @(posedge clock or negedge rst_n_i) begin
        if (!rst_n_i) begin
            clamp_rise_evt <= 1'b0;
            clamp_fall_evt <= 1'b0;
            seq_trigger    <= 1'b0;
        end else begin
            clamp_rise_evt <= rise;
            clamp_fall_evt <= fall;
            seq_trigger    <= (rise & seq_en_r[SEQ_RISE_BIT]) |
                              (fall & seq_en_r[SEQ_FALL_BIT]);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_force_a;
        @(posedge clock) disable iff (!rst_n_i)
        clamp_cfg_r.a_force |=> clamp_a_on;
    endproperty
    a_force_a: assert property (p_force_a) else $error("forced clamp a off");

    property p_sel_off;
        @(posedge clock) disable iff (!rst_n_i)
        (!clamp_cfg_r.a_force && clamp_cfg_r.a_sel == A_OFF) |=> !clamp_a_on;
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("clamp a on in off code");

    property p_single;
        @(posedge clock) disable iff (!rst_n_i)
        (!clamp_cfg_r.a_force && clamp_cfg_r.a_sel == A_B_HI) |=> (clamp_a_on == $past(js_b));
    endproperty
    a_single: assert property (p_single) else $error("single sense decode wrong");

    property p_or;
        @(posedge clock) disable iff (!rst_n_i)
        (!clamp_cfg_r.a_force && clamp_cfg_r.a_sel == A_AHI_OR_BLO)
            |=> (clamp_a_on == ($past(js_a) | ~$past(js_b)));
    endproperty
    a_or: assert property (p_or) else $error("or decode wrong");

    property p_and;
        @(posedge clock) disable iff (!rst_n_i)
        (!clamp_cfg_r.a_force && clamp_cfg_r.a_sel == A_ALO_AND_BHI)
            |=> (clamp_a_on == (~$past(js_a) & $past(js_b)));
    endproperty
    a_and: assert property (p_and) else $error("and decode wrong");

    property p_sw_follow;
        @(posedge clock) disable iff (!rst_n_i)
        (sw_cfg_r.b == SW_IF_CLR) |=> (switch_b_closed == !$past(status_r));
    endproperty
    a_sw_follow: assert property (p_sw_follow) else $error("switch b not inverse");

    property p_sw_fixed;
        @(posedge clock) disable iff (!rst_n_i)
        (sw_cfg_r.a == SW_OPEN) ##1 (sw_cfg_r.a == SW_OPEN) |-> !switch_a_closed;
    endproperty
    a_sw_fixed: assert property (p_sw_fixed) else $error("switch a not open");

    property p_forced_hidden;
        @(posedge clock) disable iff (!rst_n_i)
        (clamp_cfg_r.a_force && clamp_cfg_r.b_force && !db_en_r) [*3] |-> !status_r;
    endproperty
    a_forced_hidden: assert property (p_forced_hidden) else $error("forced clamp shown");

    property p_reserved;
        @(posedge clock) disable iff (!rst_n_i)
        (!clamp_cfg_r.a_force && clamp_cfg_r.a_sel inside {4'h2, 4'h3, 4'he, 4'hf})
            |=> !clamp_a_on;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code drives clamp");

    property p_rise_cause;
        @(posedge clock) disable iff (!rst_n_i)
        clamp_rise_evt |-> ($past(status_r) && !$past(status_prev_r));
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("rise event without edge");

    property p_seq_gate;
        @(posedge clock) disable iff (!rst_n_i)
        (seq_en_r == 2'h0) [*2] |-> !seq_trigger;
    endproperty
    a_seq_gate: assert property (p_seq_gate) else $error("sequencer started disabled");

    property p_apb_ready;
        @(posedge clock) disable iff (!rst_n_i)
        (psel && penable && !pready) |=> pready;
    endproperty
    a_apb_ready: assert property (p_apb_ready) else $error("apb ready late");

    c_rise:  cover property (@(posedge clock) disable iff (!rst_n_i) clamp_rise_evt);
    c_fall:  cover property (@(posedge clock) disable iff (!rst_n_i) clamp_fall_evt);
    c_seq:   cover property (@(posedge clock) disable iff (!rst_n_i) seq_trigger);
    c_sw_op: cover property (@(posedge clock) disable iff (!rst_n_i)
                 switch_a_closed ##1 !switch_a_closed);

endmodule

`default_nettype wire

// >>> logic/jcsc_pkg.sv
/*
 jcsc_pkg: register indices, field positions, reset values, mode codes and
 carrier types for the jack clamp and switch control block.
 assumes: byte address of a register is four times its index.
*/
`default_nettype none

package jcsc_pkg;

    // ----------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ----------------------------------------------------------------
    localparam int           ADDR_W        = 16;
    localparam int           DATA_W        = 32;
    localparam logic [13:0]  IDX_SEQ_CTRL  = 14'h0041;
    localparam logic [13:0]  IDX_CLAMP_CTL = 14'h02c6;
    localparam logic [13:0]  IDX_GP_SWITCH = 14'h02c8;
    localparam logic [13:0]  IDX_RAW_STS_A = 14'h1886;
    localparam logic [13:0]  IDX_RAW_STS_B = 14'h1986;
    localparam logic [13:0]  IDX_DB_CTRL   = 14'h1a06;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int A_SEL_LSB    = 0;
    localparam int A_FORCE_BIT  = 4;
    localparam int B_SEL_LSB    = 6;
    localparam int B_FORCE_BIT  = 9;
    localparam int SW_A_LSB     = 0;
    localparam int SW_B_LSB     = 2;
    localparam int STS_BIT      = 4;
    localparam int DB_BIT       = 4;
    localparam int SEQ_FALL_BIT = 0;
    localparam int SEQ_RISE_BIT = 1;

    // ----------------------------------------------------------------
    // condition codes
    // ----------------------------------------------------------------
    localparam logic [3:0] A_OFF       = 4'h0;
    localparam logic [3:0] A_ON        = 4'h1;
    localparam logic [3:0] A_A_LO      = 4'h4;
    localparam logic [3:0] A_A_HI      = 4'h5;
    localparam logic [3:0] A_B_LO      = 4'h6;
    localparam logic [3:0] A_B_HI      = 4'h7;
    localparam logic [3:0] A_ALO_OR_BLO = 4'h8;
    localparam logic [3:0] A_ALO_OR_BHI = 4'h9;
    localparam logic [3:0] A_AHI_OR_BLO = 4'ha;
    localparam logic [3:0] A_AHI_OR_BHI = 4'hb;
    localparam logic [3:0] A_ALO_AND_BLO = 4'hc;
    localparam logic [3:0] A_ALO_AND_BHI = 4'hd;
    localparam logic [2:0] B_OFF       = 3'h0;
    localparam logic [2:0] B_ON        = 3'h1;
    localparam logic [2:0] B_C_LO      = 3'h2;
    localparam logic [2:0] B_C_HI      = 3'h3;
    localparam logic [1:0] SW_OPEN     = 2'h0;
    localparam logic [1:0] SW_CLOSED   = 2'h1;
    localparam logic [1:0] SW_IF_SET   = 2'h2;
    localparam logic [1:0] SW_IF_CLR   = 2'h3;

    // ----------------------------------------------------------------
    // carrier types and reset values
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       b_force;
        logic [2:0] b_sel;
        logic       rsvd;
        logic       a_force;
        logic [3:0] a_sel;
    } jcsc_clamp_cfg_t;

    typedef struct packed {
        logic [1:0] b;
        logic [1:0] a;
    } jcsc_switch_cfg_t;

    localparam jcsc_clamp_cfg_t  CLAMP_RST  = 10'h210;
    localparam jcsc_switch_cfg_t SWITCH_RST = 4'h0;
    localparam logic             DB_RST     = 1'b0;
    localparam logic [1:0]       SEQ_RST    = 2'h0;
    localparam int               DB_TICKS   = 4;

endpackage

`default_nettype wire

// >>> logic/jcsc_sync.sv
/*
 jcsc_sync: three-stage input synchroniser per bit; the output follows
 once the second and third stages agree.
 assumes: inputs are asynchronous to clock.
*/
`timescale 1ns/1ps
`default_nettype none

module jcsc_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,   // system clock
    input  wire logic         rst_n,   // synced reset, active low
    input  wire logic [W-1:0] din,     // asynchronous inputs
    output logic      [W-1:0] dout     // synchronised, agreed level
);

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // shift chain; stage 1 feeds only stage 2
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // accept a bit only when the two late stages agree
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dout <= '0;
        end else begin
            dout <= (s3_r & ~(s2_r ^ s3_r)) | (dout & (s2_r ^ s3_r));
        end
    end

endmodule

`default_nettype wire

// >>> logic/jcsc_debounce.sv
/*
 jcsc_debounce: passes a level straight through when disabled, otherwise
 moves only after it has held steady for TICKS slow-clock ticks.
 assumes: tick is a one-cycle pulse on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module jcsc_debounce #(
    parameter int TICKS = 4
) (
    input  wire logic clock,   // system clock
    input  wire logic rst_n,   // synced reset, active low
    input  wire logic raw,     // undebounced level
    input  wire logic tick,    // slow clock tick pulse
    input  wire logic enable,  // debounce on
    output logic      dout     // debounced level
);

    logic [7:0] cnt_r;

    // settle counter restarts whenever input matches output
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 8'h00;
            dout  <= 1'b0;
        end else if (!enable || raw == dout) begin
            cnt_r <= 8'h00;
            dout  <= raw;
        end else if (tick) begin
            if (cnt_r == 8'(TICKS - 1)) begin
                cnt_r <= 8'h00;
                dout  <= raw;
            end else begin
                cnt_r <= cnt_r + 8'h01;
            end
        end
    end

endmodule

`default_nettype wire

// >>> bench/jcsc_jack_model.sv
/* jcsc_jack_model: jack sense pins and slow clock seen by the block.
 assumes: the bench sets the wanted pin levels. */
`timescale 1ns/1ps
`default_nettype none
module jcsc_jack_model (
    input  wire logic [2:0] level,          // wanted levels c,b,a
    input  wire logic       clock,          // system clock
    output logic            sense_a = 1'b0, // jack detect a
    output logic            sense_b = 1'b0, // jack detect b
    output logic            sense_c = 1'b0, // jack detect c
    output logic            slow_clk = 1'b0 // sped-up tick clock
);
    logic [3:0] div_r = 4'h0;
    // pins follow level a cycle later; tick clock is clock / 16
    always @(posedge clock) begin
        {sense_c, sense_b, sense_a} <= level;
        div_r <= div_r + 4'h1;
        slow_clk <= div_r[3];
    end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
/* tb_top: register and clamp tests over apb.
 assumes: jcsc_top with one wait state per access. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import jcsc_pkg::*;
    logic              clock, rst_n, psel, penable, pwrite, sleep_mode, pready, pslverr, err;
    logic              ja, jb, jc, sclk, ca, cb, swa, swb, rise, fall, seqt, seen_r, seen_f, e;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [2:0]        lvl;
    int                failures, cmp_count, cyc;
    jcsc_jack_model jm_u (.level(lvl), .clock(clock), .sense_a(ja), .sense_b(jb),
        .sense_c(jc), .slow_clk(sclk));
    jcsc_top #(.DB_COUNT(2)) dut_u (.clock(clock), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .jack_sense_a(ja),
        .jack_sense_b(jb), .jack_sense_c(jc), .slow_clk_32k(sclk),
        .sleep_mode(sleep_mode), .clamp_a_on(ca), .clamp_b_on(cb),
        .switch_a_closed(swa), .switch_b_closed(swb), .clamp_rise_evt(rise),
        .clamp_fall_evt(fall), .seq_trigger(seqt));
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // timeout and sticky sequencer pulse catcher
    always @(posedge clock) begin
        cyc++;
        if (rise === 1'b1 && seqt === 1'b1) seen_r <= 1'b1;
        if (fall === 1'b1 && seqt === 1'b1) seen_f <= 1'b1;
        if (cyc == 40000) begin
            failures++;
            test_done;
        end
    end
    function automatic logic cond_a(logic [3:0] c, logic a, logic b);
        case (c)
            4'h1: return 1'b1;
            4'h4: return !a;
            4'h5: return a;
            4'h6: return !b;
            4'h7: return b;
            4'h8: return !a | !b;
            4'h9: return !a | b;
            4'ha: return a | !b;
            4'hb: return a | b;
            4'hc: return !a & !b;
            4'hd: return !a & b;
            default: return 1'b0;
        endcase
    endfunction
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] s);
        cmp_count++;
        if (s !== x) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic apb(input logic w, input logic [13:0] i, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic test_done;
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_n, psel, penable, pwrite, sleep_mode, seen_r, lvl} = 9'h0_00;
        {paddr, pwdata, failures, cmp_count, cyc} = '0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        chk("clamps on", 32'h3, {ca, cb});
        apb(0, IDX_CLAMP_CTL, 0);
        chk("clamp_control", 32'h0000_0210, rd);
        apb(0, IDX_GP_SWITCH, 0);
        chk("gp_switch_control", 0, rd);
        apb(0, IDX_DB_CTRL, 0);
        chk("debounce", 0, rd);
        apb(1, IDX_DB_CTRL, 32'h0000_0010);
        apb(0, IDX_DB_CTRL, 0);
        chk("debounce", 32'h0000_0010, rd);
        apb(1, IDX_DB_CTRL, 0);
        apb(0, 14'h0100, 0);
        chk("unmapped", 1, err);
        // every clamp a code at every sense level
        for (int c = 0; c < 64; c++) begin
            lvl <= {1'b0, c[1], c[0]};
            apb(1, IDX_CLAMP_CTL, 32'h200 | (c >> 2));
            repeat (10) @(posedge clock);
            e = cond_a(4'(c >> 2), c[0], c[1]);
            chk("clamp_a_on", 32'(e), 32'(ca));
            apb(0, IDX_RAW_STS_B, 0);
            chk("status b", 32'(e) << STS_BIT, rd);
            apb(0, IDX_RAW_STS_A, 0);
            chk("status a", 32'(e) << STS_BIT, rd);
        end
        // clamp b codes with clamp a forced
        for (int c = 0; c < 8; c++) begin
            lvl <= {c[0], 2'b00};
            apb(1, IDX_CLAMP_CTL, 32'h10 | ((c >> 1) << 6));
            repeat (10) @(posedge clock);
            e = (c >> 1 == 1) | (c >> 1 == 2 & !c[0]) | (c >> 1 == 3 & c[0]);
            chk("clamp_b_on", 32'(e), 32'(cb));
            chk("clamp_a_on", 1, 32'(ca));
            apb(0, IDX_RAW_STS_A, 0);
            chk("status", 32'(e) << STS_BIT, rd);
        end
        // switch modes at both status values
        for (int c = 0; c < 8; c++) begin
            apb(1, IDX_CLAMP_CTL, 32'h200 | (c >> 2));
            apb(1, IDX_GP_SWITCH, 32'((c & 3) * 5));
            repeat (4) @(posedge clock);
            e = (c % 4 == 1) | (c % 4 == 2 & c >= 4) | (c % 4 == 3 & c < 4);
            chk("switches", 32'({e, e}), 32'({swa, swb}));
        end
        // removal by sense a falling, code 4 active, status debounced
        apb(1, IDX_SEQ_CTRL, 32'h3);
        apb(1, IDX_DB_CTRL, 32'h0000_0010);
        lvl <= 3'b001;
        apb(1, IDX_CLAMP_CTL, 32'h204);
        repeat (48) @(posedge clock);
        seen_r <= 1'b0;
        lvl <= 3'b000;
        repeat (12) @(posedge clock);
        chk("clamp on at removal", 1, 32'(ca));
        chk("switch a before debounce", 1, 32'(swa));
        repeat (48) @(posedge clock);
        chk("switch a after debounce", 0, 32'(swa));
        chk("rise and sequencer", 1, 32'(seen_r));
        // insertion while asleep: no debounce, fall starts the sequencer
        seen_f <= 1'b0;
        sleep_mode <= 1'b1;
        lvl <= 3'b001;
        repeat (12) @(posedge clock);
        chk("sleep skips debounce", 1, 32'(swa));
        chk("fall and sequencer", 1, 32'(seen_f));
        apb(1, IDX_CLAMP_CTL, 32'h211);
        apb(0, IDX_RAW_STS_A, 0);
        chk("forced status", 0, rd);
        // second reset in mid-run
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        repeat (4) @(posedge clock);
        chk("clamps on after reset", 32'h3, {ca, cb});
        apb(0, IDX_CLAMP_CTL, 0);
        chk("clamp_control after reset", 32'h0000_0210, rd);
        test_done;
    end
endmodule
`default_nettype wire
